// file: hw/hsc_top.sv
// Halt standby controller: core clock gating, release and resume wait.
`timescale 1ns/1ps
module hsc_top
   import hsc_pkg::*;
(
   // Clock and reset.
   input  wire logic                      clock,
   input  wire logic                      resetn,
   // Core side.
   input  wire logic                      halt_exec,
   input  wire hsc_pkg::hsc_irq_s         irq,
   input  wire logic [hsc_pkg::PORT_W-1:0] port_wdata,
   input  wire logic                      port_we,
   // Clock conditions.
   input  wire hsc_pkg::hsc_clk_s         clk_cond,
   // Core control outputs.
   output logic                           core_clk_en,
   output logic                           halted,
   output logic                           take_vector,
   output logic                           resume_next,
   // Peripheral gates.
   output logic                           reg_normal_power,
   output logic                           wdt_clk_en,
   output logic                           buzzer_en,
   output logic [hsc_pkg::PORT_W-1:0]     port_latch
);
   import hsc_pkg::*;

   hsc_state_e state_q;
   hsc_state_e state_d;
   logic       vec_q;
   logic       wait_load;
   logic       wait_done;
   logic       wake;

   // Unmasked pending request; masked ones are ignored.
   function automatic logic unmasked(input hsc_irq_s i);
      unmasked = |(i.req & ~i.mask);
   endfunction

   assign wake      = unmasked(irq); // [RQ9] [RQ15]
   assign wait_load = (state_q == HSC_HALT) && wake;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         HSC_RUN:  if (halt_exec) state_d = HSC_HALT; // [RQ1]
         HSC_HALT: if (wake) state_d = HSC_WAIT; // [RQ8]
         HSC_WAIT: if (wait_done) state_d = HSC_RUN;
         default:  state_d = HSC_RUN;
      endcase
   end

   // Asynchronous reset ends standby and restarts from the reset vector.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_q <= HSC_RUN; // [RQ14]
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         vec_q <= 1'b0;
      end else if (wait_load) begin
         vec_q <= irq.accept_en;
      end
   end

   hsc_wait_timer u_wait (
      .clock  (clock),
      .resetn (resetn),
      .load   (wait_load),
      .count  (irq.accept_en ? WAIT_VEC : WAIT_NEXT), // [RQ12] [RQ13]
      .done   (wait_done)
   );

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         core_clk_en <= 1'b1;
         halted      <= 1'b0;
      end else begin
         core_clk_en <= (state_d == HSC_RUN); // [RQ2]
         halted      <= (state_d != HSC_RUN);
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         take_vector <= 1'b0;
         resume_next <= 1'b0;
      end else begin
         take_vector <= wait_done && vec_q; // [RQ10]
         resume_next <= wait_done && !vec_q; // [RQ11]
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         port_latch <= PORT_RST;
      end else if (port_we && state_q == HSC_RUN && !halt_exec) begin
         port_latch <= port_wdata; // [RQ4]
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         reg_normal_power <= 1'b1;
         wdt_clk_en       <= 1'b0;
         buzzer_en        <= 1'b0;
      end else begin
         reg_normal_power <= clk_cond.low_osc_run || (state_q == HSC_RUN); // [RQ3]
         wdt_clk_en <= !(halted && clk_cond.low_osc_sw_stop); // [RQ5]
         buzzer_en  <= clk_cond.periph_clk_run; // [RQ6]
      end
   end

   // Clocks since the last standby release, vectored or not; holds at 31.
   logic [4:0] rel_cnt_q;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rel_cnt_q <= 5'h00;
      end else if (wait_load) begin
         rel_cnt_q <= 5'h01;
      end else if (rel_cnt_q != 5'h00 && rel_cnt_q != 5'h1f) begin
         rel_cnt_q <= rel_cnt_q + 5'h01;
      end
   end

   a_halt_gates_core: assert property (@(posedge clock) disable iff (!resetn)
      (state_q == HSC_RUN && halt_exec) |=> !core_clk_en) // [RQ2]
      else $error("core clock not gated on halt");
   a_masked_holds: assert property (@(posedge clock) disable iff (!resetn)
      (state_q == HSC_HALT && !wake) |=> state_q == HSC_HALT) // [RQ15]
      else $error("masked request left standby");
   a_unmasked_wakes: assert property (@(posedge clock) disable iff (!resetn)
      (state_q == HSC_HALT && wake) |=> state_q == HSC_WAIT) // [RQ9]
      else $error("unmasked request did not release");
   a_vec_wait_len: assert property (@(posedge clock) disable iff (!resetn)
      (wait_load && irq.accept_en) |-> ##[11:12] take_vector) // [RQ12]
      else $error("vectored wait not 11 or 12 clocks");
   a_next_wait_len: assert property (@(posedge clock) disable iff (!resetn)
      (wait_load && !irq.accept_en) |-> ##[4:5] resume_next) // [RQ13]
      else $error("resume wait not 4 or 5 clocks");
   a_vec_no_next: assert property (@(posedge clock) disable iff (!resetn)
      take_vector |-> !resume_next && core_clk_en) // [RQ10]
      else $error("vector and resume together");
   a_port_frozen: assert property (@(posedge clock) disable iff (!resetn)
      (halted && $past(halted)) |-> $stable(port_latch)) // [RQ4]
      else $error("port latch changed in standby");
   a_wdt_gate: assert property (@(posedge clock) disable iff (!resetn)
      ($past(halted) && $past(clk_cond.low_osc_sw_stop)) |-> !wdt_clk_en) // [RQ5]
      else $error("watchdog clock not gated");
   a_buzzer_stop: assert property (@(posedge clock) disable iff (!resetn)
      !$past(clk_cond.periph_clk_run) |-> !buzzer_en) // [RQ6]
      else $error("buzzer runs without peripheral clock");
   a_reg_normal: assert property (@(posedge clock) disable iff (!resetn)
      $past(clk_cond.low_osc_run) |-> reg_normal_power) // [RQ3]
      else $error("regulator not normal with low-speed osc");
   a_only_wake: assert property (@(posedge clock) disable iff (!resetn)
      (state_q == HSC_HALT && state_d != HSC_HALT) |-> wake) // [RQ8]
      else $error("standby ended without source");

   c_vec_release: cover property (@(posedge clock) disable iff (!resetn)
      take_vector);
   c_next_release: cover property (@(posedge clock) disable iff (!resetn)
      resume_next);
   c_masked_hold: cover property (@(posedge clock) disable iff (!resetn)
      state_q == HSC_HALT && |irq.req && !wake);
   c_long_vec: cover property (@(posedge clock) disable iff (!resetn)
      rel_cnt_q == 5'h0c);
endmodule // hsc_top

// file: hw/hsc_pkg.sv
// Package of constants and carrier types for the halt standby controller.
// Operation
// (RQ1) Halt instruction enters standby; stay there until a release source occurs.
// (RQ2) In standby the core clock is gated and no instruction runs.
// (RQ3) Regulator runs normal power whenever the low-speed oscillator runs.
// (RQ4) Port output latches keep their values from standby entry.
// (RQ5) Watchdog runs in standby unless option lets software stop low-speed oscillator.
// (RQ6) Buzzer runs in standby but stops when the peripheral clock stops.
// (RQ7) Software avoids pin-clocked timers or serial units on subclock, fast osc off.
// (RQ8) Only an unmasked interrupt or a reset ends standby.
// (RQ9) Any unmasked pending interrupt releases standby at once.
// (RQ10) Release with acceptance enabled branches to the interrupt vector.
// (RQ11) Release with acceptance disabled resumes at the next instruction.
// (RQ12) Vectored release waits 11 or 12 clocks before servicing.
// (RQ13) Non-vectored release waits 4 or 5 clocks before resuming.
// (RQ14) Reset during standby ends it and restarts from the reset vector.
// (RQ15) A masked pending interrupt does not end standby.
package hsc_pkg;
   localparam int unsigned IRQ_W        = 8;
   localparam int unsigned PORT_W       = 16;
   localparam logic [3:0]  WAIT_VEC     = 4'hb;
   localparam logic [3:0]  WAIT_NEXT    = 4'h4;
   localparam logic [PORT_W-1:0] PORT_RST = 16'h0000;

   typedef enum logic [1:0] {
      HSC_RUN  = 2'b00,
      HSC_HALT = 2'b01,
      HSC_WAIT = 2'b10
   } hsc_state_e;

   typedef struct packed {
      logic [IRQ_W-1:0] req;
      logic [IRQ_W-1:0] mask;
      logic             accept_en;
   } hsc_irq_s;

   typedef struct packed {
      logic low_osc_run;
      logic low_osc_sw_stop;
      logic periph_clk_run;
   } hsc_clk_s;
endpackage

// file: hw/hsc_wait_timer.sv
// Down counter that times the wait after a standby release.
`timescale 1ns/1ps
module hsc_wait_timer
   import hsc_pkg::*;
(
   // Clock and reset.
   input  wire logic       clock,
   input  wire logic       resetn,
   // Control.
   input  wire logic       load,
   input  wire logic [3:0] count,
   // Status.
   output logic            done
);
   logic [3:0] cnt_q;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 4'h0;
      end else if (load) begin
         cnt_q <= count;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         done <= 1'b0;
      end else begin
         // Firing one count early offsets the registered pulse stage in
         // the top, so the pulse lands on the loaded count of clocks.
         done <= !load && (cnt_q == 4'h2);
      end
   end
endmodule // hsc_wait_timer

// file: sim/hsc_core_model.sv
// Model of the core and interrupt controller facing the standby controller.
`timescale 1ns/1ps
module hsc_core_model
   import hsc_pkg::*;
(
   // Clock.
   input  wire logic      clock,
   // Core requests.
   output logic           halt_exec,
   output hsc_pkg::hsc_irq_s irq
);
   import hsc_pkg::*;
   initial begin
      halt_exec = 1'b0;
      irq       = '0;
   end
   // Software never starts pin-clocked units here.
   task automatic halt();
      @(posedge clock);
      halt_exec <= 1'b1;
      @(posedge clock);
      halt_exec <= 1'b0;
   endtask
   task automatic raise(input logic [IRQ_W-1:0] r, m, input logic a);
      @(posedge clock);
      irq <= '{req: r, mask: m, accept_en: a};
   endtask
endmodule // hsc_core_model

// file: sim/tb_top.sv
// Self-checking bench for the halt standby controller.
`timescale 1ns/1ps
module tb_top;
   import hsc_pkg::*;
   logic              clock, resetn, halt_exec, port_we, core_clk_en, halted;
   logic              take_vector, resume_next, reg_normal_power;
   logic              wdt_clk_en, buzzer_en;
   logic [PORT_W-1:0] port_wdata, port_latch;
   hsc_irq_s          irq;
   hsc_clk_s          clk_cond;
   int                miscompares, num_checks, n;
   int                cycles = 0;
   // Rows: low osc run, soft stop, periph run; regulator, watchdog, buzzer.
   logic [5:0] rows [4] = '{6'b100_110, 6'b110_100, 6'b011_001, 6'b101_111};

   hsc_core_model hsc_core_model_i (.clock, .halt_exec, .irq);
   hsc_top hsc_top_i (.clock, .resetn, .halt_exec, .irq, .port_wdata,
      .port_we, .clk_cond, .core_clk_en, .halted, .take_vector,
      .resume_next, .reg_normal_power, .wdt_clk_en, .buzzer_en, .port_latch);

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic chk(input logic [15:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Halts, holds on a masked request, then wakes and times the resume.
   task automatic wake(input logic a, input int lo);
      hsc_core_model_i.halt();
      #1;
      chk(halted, 1'b1);
      chk(core_clk_en, 1'b0);
      hsc_core_model_i.raise(8'h24, 8'h24, a);
      repeat (4) @(posedge clock);
      #1;
      chk(halted, 1'b1);
      hsc_core_model_i.raise(8'h24, 8'h20, a);
      for (n = 1; n < 30; n++) begin
         @(posedge clock);
         #1;
         if (take_vector || resume_next) break;
      end
      chk(take_vector, a);
      chk(resume_next, !a);
      chk(16'(n - 1 >= lo && n - 1 <= lo + 1), 16'h1);
      chk(core_clk_en, 1'b1);
      hsc_core_model_i.raise(8'h00, 8'h00, 1'b0);
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         conclude();
      end
   end

   initial begin
      miscompares = 0;
      num_checks = 0;
      resetn = 1'b0;
      port_we = 1'b0;
      port_wdata = '0;
      clk_cond = '0;
      repeat (6) @(posedge clock);
      chk(port_latch, PORT_RST);
      chk({halted, core_clk_en}, 2'b01);
      resetn <= 1'b1;
      @(posedge clock);
      port_we <= 1'b1;
      port_wdata <= 16'h5a3c;
      @(posedge clock);
      port_we <= 1'b0;
      hsc_core_model_i.halt();
      @(posedge clock);
      port_we <= 1'b1;
      port_wdata <= 16'hffff;
      @(posedge clock);
      port_we <= 1'b0;
      foreach (rows[i]) begin
         @(posedge clock);
         clk_cond <= rows[i][5:3];
         repeat (2) @(posedge clock);
         #1;
         chk({reg_normal_power, wdt_clk_en, buzzer_en}, rows[i][2:0]);
      end
      chk(port_latch, 16'h5a3c);
      @(posedge clock);
      resetn <= 1'b0;
      #1;
      chk({halted, core_clk_en}, 2'b01);
      @(posedge clock);
      resetn <= 1'b1;
      wake(1'b1, 11);
      wake(1'b0, 4);
      conclude();
   end
endmodule // tb_top
